// File: design/psc_pkg.sv
// Package with constants and carrier types for the port statistics and control block.
package psc_pkg;

   localparam int NUM_PORTS     = 8;
   localparam int CNT_W         = 32;
   localparam int NUM_CNT       = 9;
   localparam int PORT_W        = 3;
   localparam int CNT_SEL_W     = 4;
   localparam int MIN_FRAME_LEN = 64;
   localparam int LEN_W         = 16;

   // Counter indices inside one port's set.
   localparam logic [CNT_SEL_W-1:0] CNT_TX_GOOD  = 4'h0;
   localparam logic [CNT_SEL_W-1:0] CNT_TX_BAD   = 4'h1;
   localparam logic [CNT_SEL_W-1:0] CNT_RX_GOOD  = 4'h2;
   localparam logic [CNT_SEL_W-1:0] CNT_RX_BAD   = 4'h3;
   localparam logic [CNT_SEL_W-1:0] CNT_TX_ABORT = 4'h4;
   localparam logic [CNT_SEL_W-1:0] CNT_COLL     = 4'h5;
   localparam logic [CNT_SEL_W-1:0] CNT_DROP     = 4'h6;
   localparam logic [CNT_SEL_W-1:0] CNT_RX_BCAST = 4'h7;
   localparam logic [CNT_SEL_W-1:0] CNT_RX_MCAST = 4'h8;

   localparam logic [CNT_W-1:0]  CNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_MAX  = 32'hffff_ffff;
   localparam logic [47:0]       MAC_BCAST = 48'hffff_ffff_ffff;
   localparam logic [47:0]       MAC_ZERO  = 48'h0000_0000_0000;

   // Link speed encoding.
   typedef enum logic [1:0] {
      PSC_SPD_10   = 2'b00,
      PSC_SPD_100  = 2'b01,
      PSC_SPD_1000 = 2'b10
   } psc_speed_t;

   // Flow control style; symmetric is the reset value.
   typedef enum logic [0:0] {
      PSC_FC_SYM  = 1'b0,
      PSC_FC_ASYM = 1'b1
   } psc_fc_t;

   // One port's configuration.
   typedef struct packed {
      logic       enable;
      logic       autoneg;
      psc_speed_t speed;
      logic       full_duplex;
      psc_fc_t    fc_mode;
      logic       security;
   } psc_cfg_t;

   localparam psc_cfg_t CFG_RESET = '{enable: 1'b1, autoneg: 1'b1, speed: PSC_SPD_1000,
                                      full_duplex: 1'b1, fc_mode: PSC_FC_SYM, security: 1'b0};

   // End-of-frame report from the MAC of one port.
   typedef struct packed {
      logic             valid;
      logic [LEN_W-1:0] len;
      logic             oversize;
      logic             crc_err;
      logic             align_err;
      logic             jabber;
      logic             aborted;
      logic             collision;
      logic [47:0]      dst_mac;
      logic [47:0]      src_mac;
   } psc_frame_t;

   // Link partner status as seen by the PHY.
   typedef struct packed {
      logic       link_up;
      psc_speed_t speed;
      logic       full_duplex;
      logic       pause_ok;
   } psc_phy_t;

   // Resolved status for one port.
   typedef struct packed {
      logic       link_up;
      psc_speed_t speed;
      logic       full_duplex;
      logic       flow_on;
   } psc_stat_t;

endpackage : psc_pkg

// File: design/psc_counter_mem.sv
// Memory of statistics counters with registered read port and saturating updates.
`timescale 1ns/10ps
`default_nettype none
module psc_counter_mem (
   // Clock and reset.
   input  wire logic                          clk,
   input  wire logic                          reset,
   // Clear of every counter.
   input  wire logic                          clear,
   // Increment strobes, one bit per counter per port.
   input  wire logic [psc_pkg::NUM_PORTS*psc_pkg::NUM_CNT-1:0] inc,
   // Read port.
   input  wire logic [psc_pkg::PORT_W-1:0]    rd_port,
   input  wire logic [psc_pkg::CNT_SEL_W-1:0] rd_sel,
   output var  logic [psc_pkg::CNT_W-1:0]     rd_data
);
   import psc_pkg::*;

   localparam int N = NUM_PORTS * NUM_CNT;

   logic [CNT_W-1:0] cnt_q [N];
   logic [CNT_W-1:0] cnt_d [N];
   logic [CNT_W-1:0] rd_d;

   // Next values: clear wins, otherwise count up and stick at the top.
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (clear) begin
            cnt_d[i] = CNT_ZERO;
         end else if (inc[i] && cnt_q[i] != CNT_MAX) begin
            cnt_d[i] = cnt_q[i] + 32'h0000_0001;
         end else begin
            cnt_d[i] = cnt_q[i];
         end
      end
      rd_d = cnt_q[int'(rd_port) * NUM_CNT + int'(rd_sel)];
      if (int'(rd_sel) >= NUM_CNT) begin
         rd_d = CNT_ZERO;
      end
   end

   // Register the counters and the read data.
   always_ff @(posedge clk) begin
      for (int i = 0; i < N; i++) begin
         cnt_q[i] <= reset ? CNT_ZERO : cnt_d[i];
      end
      rd_data <= reset ? CNT_ZERO : rd_d;
   end

endmodule : psc_counter_mem
`default_nettype wire

// File: design/psc_port_stats.sv
// Top of the eight-port statistics and control block.
`timescale 1ns/10ps
`default_nettype none
module psc_port_stats (
   // Clock and reset.
   input  wire logic                           clk,
   input  wire logic                           reset,
   // Configuration write: port select, value and strobe.
   input  wire logic [psc_pkg::PORT_W-1:0]     cfg_port,
   input  wire psc_pkg::psc_cfg_t              cfg_wdata,
   input  wire logic                           cfg_we,
   // Clear all counters.
   input  wire logic                           clear_req,
   // Counter read request.
   input  wire logic [psc_pkg::PORT_W-1:0]     rd_port,
   input  wire logic [psc_pkg::CNT_SEL_W-1:0]  rd_sel,
   output var  logic [psc_pkg::CNT_W-1:0]      rd_data,
   // Frame reports from the MACs.
   input  wire psc_pkg::psc_frame_t            tx_frame [psc_pkg::NUM_PORTS],
   input  wire psc_pkg::psc_frame_t            rx_frame [psc_pkg::NUM_PORTS],
   input  wire logic [psc_pkg::NUM_PORTS-1:0]  fwd_drop,
   // PHY status pins.
   input  wire psc_pkg::psc_phy_t              phy_in [psc_pkg::NUM_PORTS],
   // Gating to the MACs.
   output var  logic [psc_pkg::NUM_PORTS-1:0]  tx_allow,
   output var  logic [psc_pkg::NUM_PORTS-1:0]  rx_allow,
   output var  logic [psc_pkg::NUM_PORTS-1:0]  rx_accept,
   output var  logic [psc_pkg::NUM_PORTS-1:0]  pause_tx_en,
   output var  logic [psc_pkg::NUM_PORTS-1:0]  pause_rx_en,
   // Configuration and status readback.
   output var  psc_pkg::psc_cfg_t              cfg_rdata [psc_pkg::NUM_PORTS],
   output var  psc_pkg::psc_stat_t             stat_out  [psc_pkg::NUM_PORTS]
);
   import psc_pkg::*;

   // Decides if a frame is bad: short, oversize, CRC, alignment, jabber.
   function automatic logic frame_bad(input psc_frame_t f);
      frame_bad = (int'(f.len) < MIN_FRAME_LEN) || f.oversize || f.crc_err ||
                  f.align_err || f.jabber;
   endfunction : frame_bad

   psc_cfg_t   cfg_q [NUM_PORTS];
   psc_cfg_t   cfg_d [NUM_PORTS];
   psc_phy_t   phy_m [NUM_PORTS];
   psc_phy_t   phy_s [NUM_PORTS];
   logic [47:0] mac_q [NUM_PORTS];
   logic [47:0] mac_d [NUM_PORTS];
   logic [NUM_PORTS-1:0] mac_v_q;
   logic [NUM_PORTS-1:0] mac_v_d;
   psc_stat_t  stat_d [NUM_PORTS];
   logic [NUM_PORTS-1:0] rxacc_d;
   logic [NUM_PORTS-1:0] ptx_d;
   logic [NUM_PORTS-1:0] prx_d;
   logic [NUM_PORTS*NUM_CNT-1:0] inc;

   // Two-stage synchronisers for the PHY status pins.
   always_ff @(posedge clk) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         phy_m[p] <= reset ? '0 : phy_in[p];
         phy_s[p] <= reset ? '0 : phy_m[p];
      end
   end

   // Per-port logic: configuration, status, security and counter strobes.
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         psc_frame_t tf;
         psc_frame_t rf;
         logic       tx_ok;
         logic       rx_ok;
         logic       rx_sec_ok;
         assign tf = tx_frame[p];
         assign rf = rx_frame[p];

         // Frames only count on an enabled port; fwd_drop drops count on any port.
         assign tx_ok = tf.valid && cfg_q[p].enable;
         assign rx_ok = rf.valid && cfg_q[p].enable;
         assign rx_sec_ok = !mac_v_q[p] || (rf.src_mac == mac_q[p]);

         // Counter strobes for this port.
         always_comb begin
            inc[p*NUM_CNT + int'(CNT_TX_GOOD)]  = tx_ok && !tf.aborted && !frame_bad(tf);
            inc[p*NUM_CNT + int'(CNT_TX_BAD)]   = tx_ok && !tf.aborted && frame_bad(tf);
            inc[p*NUM_CNT + int'(CNT_RX_GOOD)]  = rx_ok && rx_sec_ok && !frame_bad(rf);
            inc[p*NUM_CNT + int'(CNT_RX_BAD)]   = rx_ok && frame_bad(rf);
            inc[p*NUM_CNT + int'(CNT_TX_ABORT)] = tx_ok && tf.aborted;
            inc[p*NUM_CNT + int'(CNT_COLL)]     = tx_ok && tf.collision;
            inc[p*NUM_CNT + int'(CNT_DROP)]     = fwd_drop[p] ||
                                                  (rx_ok && !frame_bad(rf) && !rx_sec_ok);
            inc[p*NUM_CNT + int'(CNT_RX_BCAST)] = rx_ok && !frame_bad(rf) &&
                                                  rf.dst_mac == MAC_BCAST;
            inc[p*NUM_CNT + int'(CNT_RX_MCAST)] = rx_ok && !frame_bad(rf) &&
                                                  rf.dst_mac[40] &&
                                                  rf.dst_mac != MAC_BCAST;
         end

         // Next configuration, status and learned address.
         always_comb begin
            cfg_d[p]  = cfg_q[p];
            mac_d[p]  = mac_q[p];
            mac_v_d[p] = mac_v_q[p];
            if (cfg_we && int'(cfg_port) == p) begin
               cfg_d[p] = cfg_wdata;
            end
            // Learn the first good source, forget it when security goes off.
            if (!cfg_q[p].security) begin
               mac_v_d[p] = 1'b0;
            end else if (rx_ok && !frame_bad(rf) && !mac_v_q[p]) begin
               mac_d[p]   = rf.src_mac;
               mac_v_d[p] = 1'b1;
            end
            stat_d[p].link_up = phy_s[p].link_up;
            // Negotiated result when auto is on, forced settings otherwise.
            if (cfg_q[p].autoneg) begin
               stat_d[p].speed       = phy_s[p].speed;
               stat_d[p].full_duplex = phy_s[p].full_duplex;
            end else begin
               stat_d[p].speed       = cfg_q[p].speed;
               stat_d[p].full_duplex = cfg_q[p].full_duplex;
            end
            stat_d[p].flow_on = stat_d[p].full_duplex && phy_s[p].link_up &&
                                (!cfg_q[p].autoneg || phy_s[p].pause_ok);
            // Symmetric pauses both ways; asymmetric only sends pause.
            ptx_d[p] = stat_d[p].flow_on && cfg_q[p].enable;
            prx_d[p] = stat_d[p].flow_on && cfg_q[p].enable &&
                       cfg_q[p].fc_mode == PSC_FC_SYM;
            // On an enabled secured port acceptance follows the last valid report and holds between reports; otherwise it equals enable.
            rxacc_d[p] = cfg_d[p].enable && (!cfg_d[p].security ||
                         (rf.valid ? rx_sec_ok :
                          (rx_accept[p] || !cfg_q[p].enable || !cfg_q[p].security)));
         end
      end
   endgenerate

   // Register configuration, status and gating outputs.
   always_ff @(posedge clk) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (reset) begin
            cfg_q[p]    <= CFG_RESET;
            mac_q[p]    <= MAC_ZERO;
            stat_out[p] <= '0;
            cfg_rdata[p] <= CFG_RESET;
         end else begin
            cfg_q[p]    <= cfg_d[p];
            mac_q[p]    <= mac_d[p];
            stat_out[p] <= stat_d[p];
            cfg_rdata[p] <= cfg_d[p];
         end
      end
      if (reset) begin
         mac_v_q     <= '0;
         tx_allow    <= '0;
         rx_allow    <= '0;
         rx_accept   <= '0;
         pause_tx_en <= '0;
         pause_rx_en <= '0;
      end else begin
         mac_v_q <= mac_v_d;
         for (int p = 0; p < NUM_PORTS; p++) begin
            tx_allow[p] <= cfg_d[p].enable;
            rx_allow[p] <= cfg_d[p].enable;
         end
         rx_accept   <= rxacc_d;
         pause_tx_en <= ptx_d;
         pause_rx_en <= prx_d;
      end
   end

   // Counter store.
   psc_counter_mem u_mem (
      .clk     (clk),
      .reset   (reset),
      .clear   (clear_req),
      .inc     (inc),
      .rd_port (rd_port),
      .rd_sel  (rd_sel),
      .rd_data (rd_data)
   );

endmodule : psc_port_stats
`default_nettype wire

// File: verification/psc_port_stats_checker.sv
// Assertion checker for the port statistics and control block.
`timescale 1ns/10ps
`default_nettype none
module psc_port_stats_checker (
   // Clock and reset.
   input wire logic                clk,
   input wire logic                reset,
   // Inputs of the block.
   input wire logic [2:0]          cfg_port,
   input wire psc_pkg::psc_cfg_t   cfg_wdata,
   input wire logic                cfg_we,
   input wire logic                clear_req,
   input wire logic [2:0]          rd_port,
   input wire logic [3:0]          rd_sel,
   input wire psc_pkg::psc_frame_t tx_frame [8],
   input wire psc_pkg::psc_phy_t   phy_in [8],
   // Outputs of the block.
   input wire logic [31:0]         rd_data,
   input wire logic [7:0]          tx_allow,
   input wire logic [7:0]          rx_allow,
   input wire logic [7:0]          rx_accept,
   input wire logic [7:0]          pause_tx_en,
   input wire logic [7:0]          pause_rx_en,
   input wire psc_pkg::psc_cfg_t   cfg_rdata [8],
   input wire psc_pkg::psc_stat_t  stat_out [8]
);
   import psc_pkg::*;
   logic tx0_good;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Marks an error-free, unaborted transmit report on port 0.
   assign tx0_good = tx_frame[0].valid && tx_frame[0].len >= 16'h0040 && !(tx_frame[0].oversize
      || tx_frame[0].crc_err || tx_frame[0].align_err || tx_frame[0].jabber || tx_frame[0].aborted);
   a_cfg_readback: assert property (cfg_we |=>
      cfg_rdata[$past(cfg_port)] == $past(cfg_wdata)) else $error("config readback wrong");
   a_gate_enable: assert property (!$past(reset) |->
      tx_allow[0] == cfg_rdata[0].enable && rx_allow == tx_allow) else $error("gating wrong");
   a_clear_zeroes: assert property (clear_req |-> ##2 rd_data == CNT_ZERO)
      else $error("counter not cleared");
   a_count_monotone: assert property ($past(rd_port) == $past(rd_port, 2)
      && $past(rd_sel) == $past(rd_sel, 2) && !$past(clear_req, 2) && !$past(reset, 2)
      && !$past(reset) |-> rd_data >= $past(rd_data)) else $error("counter went down");
   a_tx_good_inc: assert property (tx0_good && tx_allow[0] && !clear_req
      && rd_port == 3'h0 && rd_sel == CNT_TX_GOOD ##1 rd_port == 3'h0
      && rd_sel == CNT_TX_GOOD |=> rd_data == $past(rd_data) + 32'h1)
      else $error("tx good count wrong");
   a_link_follows: assert property (!$past(reset) && !$past(reset, 2)
      && !$past(reset, 3) |-> stat_out[0].link_up == $past(phy_in[0].link_up, 3))
      else $error("link status wrong");
   a_pause_subset: assert property ((pause_rx_en & ~pause_tx_en) == 8'h00)
      else $error("pause receive without send");
   a_accept_enabled: assert property ((rx_accept & ~rx_allow) == 8'h00)
      else $error("accept on disabled port");
   // Main scenarios.
   c_clear: cover property (clear_req);
   c_disable: cover property (cfg_we && !cfg_wdata.enable);
   c_tx_good: cover property (tx0_good && tx_allow[0]);
endmodule : psc_port_stats_checker
bind psc_port_stats psc_port_stats_checker psc_port_stats_checker_i (.clk, .reset, .cfg_port,
   .cfg_wdata, .cfg_we, .clear_req, .rd_port, .rd_sel, .tx_frame, .phy_in, .rd_data, .tx_allow,
   .rx_allow, .rx_accept, .pause_tx_en, .pause_rx_en, .cfg_rdata, .stat_out);
`default_nettype wire

// File: verification/psc_link_partner.sv
// Link partner model on port 0: receive frame reports and PHY status.
`timescale 1ns/10ps
`default_nettype none
module psc_link_partner (
   // Clock and commands.
   input  wire logic                clk,
   input  wire logic                send,
   input  wire psc_pkg::psc_frame_t frm,
   input  wire logic                link,
   // Toward the block.
   output var  psc_pkg::psc_frame_t rx_frame [8],
   output var  psc_pkg::psc_phy_t   phy_in [8]
);
   import psc_pkg::*;
   // Reports last one cycle; idle fields carry the inverse of the previous cycle's fields, so they toggle.
   initial rx_frame = '{default: '0};
   always @(posedge clk) begin
      rx_frame[0] <= send ? frm : {1'b0, ~rx_frame[0][$bits(psc_frame_t)-2:0]};
   end
   // Port 0 shows a 100 Mb/s full-duplex partner that agrees to pause.
   always_comb begin
      phy_in = '{default: '0};
      phy_in[0] = '{link_up: link, speed: PSC_SPD_100, full_duplex: 1'b1, pause_ok: 1'b1};
   end
endmodule : psc_link_partner
`default_nettype wire

// File: verification/psc_port_stats_tb.sv
// Self-checking testbench for the port statistics and control block.
`timescale 1ns/10ps
`default_nettype none
module psc_port_stats_tb;
   import psc_pkg::*;
   localparam logic [47:0] UNI = 48'h0200_0000_00aa, SA = 48'h0200_0000_0001;
   localparam logic [47:0] SB  = 48'h0200_0000_0002, MC = 48'h0100_5e00_0001;
   logic       clk, reset, cfg_we, clear_req, psend, plink;
   logic [2:0] cfg_port, rd_port;
   logic [3:0] rd_sel;
   logic [31:0] rd_data;
   logic [7:0] fwd_drop, tx_allow, rx_allow, rx_accept, ptx, prx;
   psc_cfg_t   cfg_wdata, cfg_rdata [8];
   psc_stat_t  stat_out [8];
   psc_frame_t tx_frame [8], rx_frame [8], pfrm;
   psc_phy_t   phy_in [8];
   int         bad_count = 0, tests_run = 0;
   psc_port_stats psc_port_stats_i (.clk, .reset, .cfg_port, .cfg_wdata, .cfg_we, .clear_req,
      .rd_port, .rd_sel, .rd_data, .tx_frame, .rx_frame, .fwd_drop, .phy_in, .tx_allow,
      .rx_allow, .rx_accept, .pause_tx_en(ptx), .pause_rx_en(prx), .cfg_rdata, .stat_out);
   psc_link_partner psc_link_partner_i (.clk, .send(psend), .frm(pfrm), .link(plink),
      .rx_frame, .phy_in);
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic psc_frame_t mk(logic [15:0] l, logic [47:0] d, s, logic [2:0] e);
      return '{valid: 1'b1, len: l, crc_err: e[0], aborted: e[1], collision: e[2], dst_mac: d,
               src_mac: s, default: '0};
   endfunction : mk
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input logic [2:0] p, input logic [3:0] s, input logic [31:0] e);
      @(posedge clk) rd_port <= p;
      rd_sel <= s;
      @(posedge clk);
      #1 chk("rd_data", e, rd_data);
   endtask : rd
   task automatic tx(input int p, input psc_frame_t f);
      @(posedge clk) tx_frame[p] <= f;
      @(posedge clk) tx_frame[p] <= {1'b0, ~f[$bits(f)-2:0]};
   endtask : tx
   task automatic rx(input psc_frame_t f);
      @(posedge clk) psend <= 1'b1;
      pfrm <= f;
      @(posedge clk) psend <= 1'b0;
   endtask : rx
   task automatic cfg(input logic [2:0] p, input psc_cfg_t c);
      @(posedge clk) cfg_port <= p;
      cfg_wdata <= c;
      cfg_we <= 1'b1;
      @(posedge clk) cfg_we <= 1'b0;
      #1;
   endtask : cfg
   task automatic s_phy;
      chk("fc_mode", {31'h0, PSC_FC_SYM}, {31'h0, cfg_rdata[2].fc_mode});
      @(posedge clk) plink <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("link_up", 32'h1, {31'h0, stat_out[0].link_up});
      repeat (4) @(posedge clk);
      #1 chk("speed", {30'h0, PSC_SPD_100}, {30'h0, stat_out[0].speed});
      chk("pause_rx", 32'h1, {31'h0, prx[0]});
      cfg(0, '{1'b1, 1'b1, PSC_SPD_1000, 1'b1, PSC_FC_ASYM, 1'b0});
      repeat (4) @(posedge clk);
      #1 chk("pause_asym", 32'h2, {30'h0, ptx[0], prx[0]});
      cfg(0, CFG_RESET);
   endtask : s_phy
   task automatic s_tx;
      rd(0, CNT_TX_GOOD, 32'h0);
      tx(0, mk(16'h0040, UNI, SA, 3'h0));
      tx(0, mk(16'h003f, UNI, SA, 3'h0));
      tx(0, mk(16'h0100, UNI, SA, 3'h1));
      tx(0, mk(16'h0100, UNI, SA, 3'h2));
      tx(0, mk(16'h0100, UNI, SA, 3'h4));
      rd(0, CNT_TX_GOOD, 32'h2);
      rd(0, CNT_TX_BAD, 32'h2);
      rd(0, CNT_TX_ABORT, 32'h1);
      rd(0, CNT_COLL, 32'h1);
   endtask : s_tx
   task automatic s_rx;
      rx(mk(16'h0040, MAC_BCAST, SA, 3'h0));
      rx(mk(16'h0200, MC, SA, 3'h0));
      rx(mk(16'h003f, UNI, SA, 3'h0));
      rx(mk(16'h0100, UNI, SA, 3'h1));
      @(posedge clk) fwd_drop <= 8'h01;
      @(posedge clk) fwd_drop <= 8'h00;
      rd(0, CNT_RX_GOOD, 32'h2);
      rd(0, CNT_RX_BAD, 32'h2);
      rd(0, CNT_DROP, 32'h1);
      rd(0, CNT_RX_BCAST, 32'h1);
      rd(0, CNT_RX_MCAST, 32'h1);
   endtask : s_rx
   task automatic s_dis;
      psc_cfg_t c = '{1'b0, 1'b0, PSC_SPD_100, 1'b0, PSC_FC_SYM, 1'b0};
      cfg(1, c);
      chk("tx_allow", 32'h0, {31'h0, tx_allow[1]});
      chk("cfg_rdata", {25'h0, c}, {25'h0, cfg_rdata[1]});
      tx(1, mk(16'h0040, UNI, SA, 3'h0));
      rd(1, CNT_TX_GOOD, 32'h0);
      cfg(1, CFG_RESET);
      tx(1, mk(16'h0040, UNI, SA, 3'h0));
      rd(1, CNT_TX_GOOD, 32'h1);
   endtask : s_dis
   task automatic s_sec;
      cfg(0, '{1'b1, 1'b1, PSC_SPD_1000, 1'b1, PSC_FC_SYM, 1'b1});
      rx(mk(16'h0040, UNI, SA, 3'h0));
      rx(mk(16'h0040, UNI, SB, 3'h0));
      rd(0, CNT_RX_GOOD, 32'h3);
      rd(0, CNT_DROP, 32'h2);
      chk("rx_accept", 32'h0, {31'h0, rx_accept[0]});
      cfg(0, CFG_RESET);
   endtask : s_sec
   task automatic s_clr;
      @(posedge clk) clear_req <= 1'b1;
      @(posedge clk) clear_req <= 1'b0;
      for (int s = 0; s < 10; s++) rd(0, s[3:0], 32'h0);
      rd(1, CNT_TX_GOOD, 32'h0);
   endtask : s_clr
   task automatic report_and_stop;
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence after a 12-cycle reset.
   initial begin
      {reset, cfg_we, clear_req, psend, plink} = 5'h10;
      {cfg_port, rd_port, rd_sel, fwd_drop} = '0;
      cfg_wdata = CFG_RESET;
      pfrm = '0;
      tx_frame = '{default: '0};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      s_phy();
      s_tx();
      s_rx();
      s_dis();
      s_sec();
      s_clr();
      report_and_stop();
   end
   // Cuts a hang short.
   initial begin
      #100us;
      bad_count++;
      report_and_stop();
   end
endmodule : psc_port_stats_tb
`default_nettype wire
